//--- logic/cvpr_defines.vh
// Constants for the vertical pattern region generator.
`ifndef CVPR_DEFINES_VH
`define CVPR_DEFINES_VH

// ==========================================================================
// Serial write frame
`define CVPR_FRAME_BITS     24
`define CVPR_ADDR_BITS      8

// ==========================================================================
// Register map, pattern block p at p * 16
`define CVPR_PAT_STRIDE     8'h10
`define CVPR_ITEM_LEN       4'h0
`define CVPR_ITEM_LEVEL     4'h1
`define CVPR_ITEM_EDGE_LO   4'h2
`define CVPR_ITEM_EDGE_HI   4'h9
`define CVPR_ITEM_REPEAT    4'ha
`define CVPR_ADDR_BOUND     8'h40
`define CVPR_ADDR_SEQPTR    8'h48
`define CVPR_ADDR_PATSEL    8'h50

// ==========================================================================
// Reset values
`define CVPR_RST_LEN        9'h000
`define CVPR_RST_LEVEL      4'h0
`define CVPR_RST_EDGE       9'h000
`define CVPR_RST_REPEAT     8'h00
`define CVPR_RST_BOUND      8'hff
`define CVPR_RST_SEQPTR     3'h0
`define CVPR_RST_PATSEL     2'h0

// ==========================================================================
// Sequence pointer codes that alternate on even and odd lines
`define CVPR_PTR_ALT01      3'h4
`define CVPR_PTR_ALT23      3'h5

// ==========================================================================
// Pixel rate divider, core clock cycles per pixel
`define CVPR_PIX_DIV        4'hc

`endif

//--- logic/cvpr_top.v
// Vertical transfer clock generator with four patterns and five line regions.
// Functional notes
// - Field readout is built by running line regions in sequence by boundary.
// - Each boundary is an 8-bit line number compared with the line count.
// - Boundary zero is fixed at line zero; four more are software writable.
// - Four programmable boundaries give at most five regions per field.
// - Reaching a boundary switches the phase outputs to that region's pattern.
// - Each pattern has a 9-bit repetition length in pixels.
// - Per pattern and phase a start level bit: zero low, one high.
// - Two 9-bit toggle positions per phase invert the output on a match.
// - Four independent pattern configurations are held and usable at once.
// - The second toggle position is set apart from the first, forming a pulse.
// - Repetition count sets pulses per line; zero holds the start level.
// - Each region pointer picks a select setting naming the active pattern.
// - The first region begins at the vertical sync falling edge.
`timescale 1ns/100ps
`default_nettype none
`include "cvpr_defines.vh"

module cvpr_top (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // Serial register port pins
    input  wire       ser_clk,
    input  wire       ser_data,
    input  wire       ser_load_n,
    // Sync pins
    input  wire       vertical_sync,
    input  wire       horizontal_sync,
    // Vertical phase outputs, bit 0 is vertical_phase_1
    output wire [3:0] vertical_phase,
    // Status
    output reg  [7:0] line_count_ff,
    output reg  [2:0] region_ff,
    output reg  [1:0] active_pattern_ff
);

// ==========================================================================
// Input synchronisers
reg  [4:0]  sync1_ff;
reg  [4:0]  sync2_ff;
reg  [4:0]  sync3_ff;

always @(posedge core_clk) begin
    if (rst) begin
        sync1_ff <= 5'h1f;
        sync2_ff <= 5'h1f;
        sync3_ff <= 5'h1f;
    end else begin
        sync1_ff <= {horizontal_sync, vertical_sync, ser_load_n, ser_data, ser_clk};
        sync2_ff <= sync1_ff;
        sync3_ff <= sync2_ff;
    end
end

wire        sclk_rise = sync2_ff[0] & ~sync3_ff[0];
wire        sdat      = sync2_ff[1];
wire        load_rise = sync2_ff[2] & ~sync3_ff[2];
wire        vs_fall   = ~sync2_ff[3] & sync3_ff[3];
wire        hs_fall   = ~sync2_ff[4] & sync3_ff[4];

// ==========================================================================
// Serial write port
// Frames are write only, address first, least significant bit first.
reg  [23:0] shift_ff;
wire [7:0]  wr_addr   = shift_ff[7:0];
wire [15:0] wr_data   = shift_ff[23:8];

always @(posedge core_clk) begin
    if (rst) begin
        shift_ff <= 24'h000000;
    end else if (sclk_rise) begin
        shift_ff <= {sdat, shift_ff[23:1]};
    end
end

// ==========================================================================
// Configuration storage
reg  [8:0]  len_ff   [0:3];
reg  [3:0]  level_ff [0:3];
reg  [8:0]  edge_ff  [0:31];
reg  [7:0]  repeat_ff[0:3];
reg  [7:0]  bound_ff [0:3];
reg  [2:0]  seqptr_ff[0:4];
reg  [1:0]  patsel_ff[0:3];

wire [1:0]  wr_pat    = wr_addr[5:4];
wire [3:0]  wr_item   = wr_addr[3:0];
wire [3:0]  wr_eoff   = wr_item - `CVPR_ITEM_EDGE_LO;
wire        wr_is_pat = (wr_addr[7:6] == 2'h0);
integer     i;

always @(posedge core_clk) begin
    if (rst) begin
        for (i = 0; i < 4; i = i + 1) begin
            len_ff[i]    <= `CVPR_RST_LEN;
            level_ff[i]  <= `CVPR_RST_LEVEL;
            repeat_ff[i] <= `CVPR_RST_REPEAT;
            bound_ff[i]  <= `CVPR_RST_BOUND;
            patsel_ff[i] <= `CVPR_RST_PATSEL;
        end
        for (i = 0; i < 5; i = i + 1) begin
            seqptr_ff[i] <= `CVPR_RST_SEQPTR;
        end
        for (i = 0; i < 32; i = i + 1) begin
            edge_ff[i] <= `CVPR_RST_EDGE;
        end
    end else if (load_rise) begin
        if (wr_is_pat) begin
            // Each pattern keeps its own set, so all four stay ready.
            if (wr_item == `CVPR_ITEM_LEN) begin
                len_ff[wr_pat] <= wr_data[8:0];
            end
            if (wr_item == `CVPR_ITEM_LEVEL) begin
                level_ff[wr_pat] <= wr_data[3:0];
            end
            if (wr_item >= `CVPR_ITEM_EDGE_LO && wr_item <= `CVPR_ITEM_EDGE_HI) begin
                // First and second edges sit at separate addresses.
                edge_ff[{wr_pat, wr_eoff[2:0]}] <= wr_data[8:0];
            end
            if (wr_item == `CVPR_ITEM_REPEAT) begin
                repeat_ff[wr_pat] <= wr_data[7:0];
            end
        end
        if (wr_addr[7:2] == `CVPR_ADDR_BOUND >> 2) begin
            // Only boundaries one to four are writable; zero is implicit.
            bound_ff[wr_addr[1:0]] <= wr_data[7:0];
        end
        if (wr_addr >= `CVPR_ADDR_SEQPTR && wr_addr <= `CVPR_ADDR_SEQPTR + 8'h04) begin
            seqptr_ff[wr_addr[2:0]] <= wr_data[2:0];
        end
        if (wr_addr[7:2] == `CVPR_ADDR_PATSEL >> 2) begin
            patsel_ff[wr_addr[1:0]] <= wr_data[1:0];
        end
    end
end

// ==========================================================================
// Pixel rate enable
reg  [3:0]  div_ff;
reg         pix_en_ff;

always @(posedge core_clk) begin
    if (rst) begin
        div_ff    <= 4'h0;
        pix_en_ff <= 1'b0;
    end else begin
        pix_en_ff <= (div_ff == `CVPR_PIX_DIV - 4'h1);
        div_ff    <= (div_ff == `CVPR_PIX_DIV - 4'h1) ? 4'h0 : div_ff + 4'h1;
    end
end

// ==========================================================================
// Line count and region selection
wire        line_start = vs_fall | hs_fall;
// Vertical sync restarts the field at line zero, in region zero unless a boundary is written as zero.
wire [7:0]  new_line   = vs_fall ? 8'h00 : line_count_ff + 8'h01;
reg  [2:0]  new_region;
reg  [2:0]  ptr;
reg  [1:0]  sel_idx;
reg  [1:0]  new_pat;
integer     k;

// Boundaries are expected in ascending order; the last one passed wins.
always @* begin
    new_region = 3'h0;
    for (k = 0; k < 4; k = k + 1) begin
        if (new_line >= bound_ff[k]) begin
            new_region = k[2:0] + 3'h1;
        end
    end
    ptr = seqptr_ff[new_region];
    case (ptr)
        3'h0: sel_idx = 2'h0;
        3'h1: sel_idx = 2'h1;
        3'h2: sel_idx = 2'h2;
        3'h3: sel_idx = 2'h3;
        `CVPR_PTR_ALT01: sel_idx = {1'b0, new_line[0]};
        `CVPR_PTR_ALT23: sel_idx = {1'b1, new_line[0]};
        default: sel_idx = 2'h0;
    endcase
    new_pat = patsel_ff[sel_idx];
end

always @(posedge core_clk) begin
    if (rst) begin
        line_count_ff     <= 8'h00;
        region_ff         <= 3'h0;
        active_pattern_ff <= 2'h0;
    end else if (line_start) begin
        line_count_ff     <= new_line;
        region_ff         <= new_region;
        active_pattern_ff <= new_pat;
    end
end

// ==========================================================================
// Repetition sequencer
reg  [8:0]  vcnt_ff;
reg  [7:0]  reps_left_ff;
wire        counting = pix_en_ff & (reps_left_ff != 8'h00) & ~line_start;
wire [8:0]  cur_len  = len_ff[active_pattern_ff];
wire        rep_end  = (cur_len == 9'h000) | (vcnt_ff == cur_len - 9'h001);

always @(posedge core_clk) begin
    if (rst) begin
        vcnt_ff      <= 9'h000;
        reps_left_ff <= 8'h00;
    end else if (line_start) begin
        vcnt_ff      <= 9'h000;
        reps_left_ff <= repeat_ff[new_pat];
    end else if (counting) begin
        if (rep_end) begin
            // Restart per repetition so each one repeats the same pulse.
            vcnt_ff      <= 9'h000;
            reps_left_ff <= reps_left_ff - 8'h01;
        end else begin
            vcnt_ff <= vcnt_ff + 9'h001;
        end
    end
end

// ==========================================================================
// Phase outputs
// A zero length ends each repetition at once, so no edge is ever produced.
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_phase
        localparam [1:0] PH = g;
        reg         ph_ff;
        wire [8:0]  edge_a = edge_ff[{active_pattern_ff, PH, 1'b0}];
        wire [8:0]  edge_b = edge_ff[{active_pattern_ff, PH, 1'b1}];
        wire        hit    = (vcnt_ff == edge_a) | (vcnt_ff == edge_b);
        always @(posedge core_clk) begin
            if (rst) begin
                ph_ff <= 1'b0;
            end else if (line_start) begin
                ph_ff <= level_ff[new_pat][g];
            end else if (counting && hit && cur_len != 9'h000) begin
                ph_ff <= ~ph_ff;
            end
        end
        assign vertical_phase[g] = ph_ff;
    end
endgenerate

endmodule // cvpr_top
`default_nettype wire

//--- tb/cvpr_assertions.sv
// Port-level checks for the vertical pattern region generator.
`timescale 1ns/100ps
`default_nettype none
module cvpr_assertions (
    // Clock, reset and sync pins
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       vertical_sync,
    input wire logic       horizontal_sync,
    // Outputs under watch
    input wire logic [3:0] vertical_phase,
    input wire logic [7:0] line_count_ff,
    input wire logic [2:0] region_ff,
    input wire logic [1:0] active_pattern_ff
);
// ==========================================================================
// Properties
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
// Sync pins pass a two-stage synchroniser, so a line start lands a few cycles late.
sequence s_line_zero; ##[2:8] line_count_ff == 8'h00; endsequence
sequence s_line_moves; ##[2:8] $changed(line_count_ff); endsequence
a_reset_clears: assert property (disable iff (1'b0) rst |=>
    vertical_phase == 4'h0 && line_count_ff == 8'h00 && region_ff == 3'h0) else $error("no clear");
a_vsync_restart: assert property ($fell(vertical_sync) |-> s_line_zero)
    else $error("field not restarted");
a_hsync_advance: assert property ($fell(horizontal_sync) |-> s_line_moves)
    else $error("line not advanced");
a_line_steps: assert property ($changed(line_count_ff) |-> line_count_ff == 8'h00
    || line_count_ff == $past(line_count_ff) + 8'h01) else $error("line jump");
a_region_range: assert property (region_ff <= 3'h4) else $error("region too big");
a_region_at_line: assert property ($changed(region_ff) |->
    $changed(line_count_ff) || line_count_ff == 8'h00) else $error("region mid line");
a_pattern_at_line: assert property ($changed(active_pattern_ff) |->
    $changed(line_count_ff) || line_count_ff == 8'h00) else $error("pattern mid line");
// A line start may cut a repetition short, so only a pixel toggle must stay apart.
a_toggle_spacing: assert property ($changed(vertical_phase) && $stable(line_count_ff)
    |=> ($stable(vertical_phase) || $changed(line_count_ff) || line_count_ff == 8'h00) [*8])
    else $error("toggle off pixel grid");
endmodule // cvpr_assertions
bind cvpr_top cvpr_assertions i_chk (.core_clk(core_clk), .rst(rst),
    .vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync),
    .vertical_phase(vertical_phase), .line_count_ff(line_count_ff),
    .region_ff(region_ff), .active_pattern_ff(active_pattern_ff));
`default_nettype wire

//--- tb/cvpr_ccd_model.sv
// Vertical driver stand-in that counts phase one pulses.
`timescale 1ns/100ps
`default_nettype none
module cvpr_ccd_model (
    // Clock and control
    input wire logic       core_clk,
    input wire logic       clear,
    // Phase inputs and pulse count
    input wire logic [3:0] vertical_phase,
    output logic     [7:0] rise_cnt_ff
);
// ==========================================================================
// Pulse counter
logic prev_ff;
always @(posedge core_clk) begin
    prev_ff <= vertical_phase[0];
    if (clear) rise_cnt_ff <= 8'h00;
    else if (vertical_phase[0] && !prev_ff) rise_cnt_ff <= rise_cnt_ff + 8'h01;
end
endmodule // cvpr_ccd_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the vertical pattern region generator.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
// ==========================================================================
// Pins, instances and helpers
logic       core_clk, rst, sclk, sdat, sld_n, vs, hs, clr;
logic [3:0] ph;
logic [7:0] line, cnt;
logic [2:0] rgn;
logic [1:0] pat;
int         num_errors = 0, tests_run = 0, cyc = 0;
cvpr_top i_dut (.core_clk(core_clk), .rst(rst), .ser_clk(sclk), .ser_data(sdat),
    .ser_load_n(sld_n), .vertical_sync(vs), .horizontal_sync(hs), .vertical_phase(ph),
    .line_count_ff(line), .region_ff(rgn), .active_pattern_ff(pat));
cvpr_ccd_model i_ccd (.core_clk(core_clk), .clear(clr), .vertical_phase(ph),
    .rise_cnt_ff(cnt));
initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
end
task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
        num_errors++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
endtask
// Serial pins are slow: every clock level holds four core cycles and each data bit eight, so the synchroniser sees it.
task automatic ser_wr(logic [7:0] a, logic [15:0] d);
    logic [23:0] f;
    f = {d, a};
    sld_n = 0;
    tick(4);
    for (int i = 0; i < 24; i++) begin
        sdat = f[i];
        sclk = 0;
        tick(4);
        sclk = 1;
        tick(4);
    end
    sld_n = 1;
    sclk = 0;
    tick(8);
endtask
task automatic sync(bit v);
    if (v) vs = 0;
    else hs = 0;
    tick(6);
    vs = 1;
    hs = 1;
    tick(6);
endtask
task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
// ==========================================================================
// Scenarios
task automatic t_reset;
    chk("line", line, 8'h00);
    chk("outputs", {rgn, pat, ph[2:0]}, 8'h00);
    $display("t_reset done");
endtask
task automatic t_pulse;
    logic [8:0] ln;
    logic [7:0] rp;
    ser_wr(8'h01, 16'h000a);
    ser_wr(8'h02, 16'h0001);
    ser_wr(8'h03, 16'h0003);
    for (int k = 0; k < 4; k++) begin
        ln = (k == 3) ? 9'h003 : 9'h004;
        rp = (k == 3) ? 8'h01 : 8'(k);
        ser_wr(8'h00, {7'h00, ln});
        ser_wr(8'h0a, {8'h00, rp});
        clr = 1;
        tick(1);
        clr = 0;
        sync(0);
        tick(150);
        chk("pulses", cnt, rp);
        chk("levels", {4'h0, ph}, {4'h0, 3'b101 ^ {3{rp[0]}}, ln == 9'h003});
    end
    $display("t_pulse done");
endtask
task automatic t_region;
    logic [7:0] r;
    for (int b = 0; b < 4; b++) ser_wr(8'(8'h40 + b), 16'(2 * b + 2));
    for (int b = 0; b < 5; b++) ser_wr(8'(8'h48 + b), 16'(b));
    for (int b = 0; b < 4; b++) ser_wr(8'(8'h50 + b), 16'(3 - b));
    sync(1);
    for (int l = 0; l < 10; l++) begin
        if (l > 0) sync(0);
        r = (l >= 8) ? 8'h04 : 8'(l / 2);
        chk("line", line, 8'(l));
        chk("region", {5'h00, rgn}, r);
        chk("pattern", {6'h00, pat}, (r < 4) ? 8'(3 - r) : 8'(3 - l % 2));
    end
    sync(1);
    chk("restart", {line[4:0], rgn}, 8'h00);
    $display("t_region done");
endtask
always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
        num_errors++;
        end_sim();
    end
end
initial begin
    rst = 1;
    {sclk, sdat, clr} = 3'h0;
    {sld_n, vs, hs} = 3'h7;
    tick(12);
    rst = 0;
    tick(2);
    t_reset();
    t_pulse();
    t_region();
    end_sim();
end
endmodule // tb_top
`default_nettype wire
